// ### design/system_clock_source_control.sv
// Purpose: Clock-source selection, crystal start-up and internal
//          oscillator enables for the oscillator unit.
// Assumes: All pin and configuration inputs are synchronous to ref_clk.
// Notes:   Oscillators are modelled as enable pulses on one clock.
`timescale 1ns/1ps
module system_clock_source_control #(
   parameter int unsigned XTAL_COUNT = clk_src_pkg::XTAL_STARTUP_CYCLES
) (
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   input  wire logic [2:0] osc_mode_cfg,
   input  wire logic       nv_multiplier_enable,
   input  wire logic       clock_output_pin_config,
   input  wire logic       clock_failure_monitor_en,
   input  wire logic       dual_speed_en,
   input  wire logic       power_up_delay_en,
   input  wire logic       power_up_delay_done,
   input  wire logic       sleep_wake,
   input  wire logic       primary_osc_input_pin,
   input  wire logic       secondary_osc_tick,
   input  wire logic       sw_multiplier_enable,
   input  wire logic [1:0] clk_select_wr_data,
   input  wire logic       clk_select_wr,
   input  wire logic [3:0] freq_select_wr_data,
   input  wire logic       freq_select_wr,
   input  wire logic [5:0] trim_wr_data,
   input  wire logic       trim_wr,
   output logic [1:0]      clk_select,
   output logic [3:0]      internal_freq_select,
   output logic [5:0]      frequency_trim,
   output logic            multiplier_on,
   output logic            hf_ready_flag,
   output logic            hf_locked_flag,
   output logic            hf_stable_flag,
   output logic            mf_ready_flag,
   output logic            hf_enable,
   output logic            mf_enable,
   output logic            lf_enable,
   output logic            xtal_startup_done,
   output logic            cpu_hold,
   output logic            sys_clk_tick,
   output logic            osc_out_pin_is_clkout,
   output logic            osc_in_pin_is_gpio
);
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WAIT_POWER_UP_DELAY_TIMER,
      ST_COUNT,
      ST_DONE
   } start_state_t;

   start_state_t state_q, state_d;
   logic [1:0]   sel_q, sel_d;
   logic [3:0]   fsel_q, fsel_d;
   logic [5:0]   trim_q, trim_d;
   logic         first_q, first_d;
   logic         xstart;
   logic         xdone;
   logic         xtal_mode;
   logic         ext_mode;
   logic         intsel, intrun;
   logic         hf_en, mf_en, lf_en;
   logic         hf_rdy, hf_lck, hf_stb, hf_tick;
   logic         mf_rdy, mf_tick;
   logic         lf_tick;
   logic         fast_rdy;
   logic         sys_tick;
   logic [3:0]   shift;

   // Register updates from software.
   always_comb begin
      sel_d  = sel_q;
      fsel_d = fsel_q;
      trim_d = trim_q;
      if (clk_select_wr) begin
         sel_d = clk_select_wr_data;
      end
      if (freq_select_wr) begin
         fsel_d = freq_select_wr_data;
      end
      if (trim_wr) begin
         trim_d = trim_wr_data;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sel_q  <= clk_src_pkg::SEL_RESET;
         fsel_q <= clk_src_pkg::FREQ_SEL_RESET;
         trim_q <= clk_src_pkg::TRIM_RESET;
      end else begin
         sel_q  <= sel_d;
         fsel_q <= fsel_d;
         trim_q <= trim_d;
      end
   end

   assign xtal_mode = (osc_mode_cfg == clk_src_pkg::MODE_LP) ||
                      (osc_mode_cfg == clk_src_pkg::MODE_XT) ||
                      (osc_mode_cfg == clk_src_pkg::MODE_HS);
   assign ext_mode  = (osc_mode_cfg == clk_src_pkg::MODE_ECL) ||
                      (osc_mode_cfg == clk_src_pkg::MODE_ECM) ||
                      (osc_mode_cfg == clk_src_pkg::MODE_ECH);

   // Start-up sequencer: power-on in crystal modes waits for the optional delay timer.
   always_comb begin
      state_d = state_q;
      first_d = 1'b0;
      xstart  = 1'b0;
      unique case (state_q)
         ST_IDLE: begin
            if (!xtal_mode) begin
               state_d = ST_DONE;
            end else if (power_up_delay_en && !power_up_delay_done) begin
               state_d = ST_WAIT_POWER_UP_DELAY_TIMER;
            end else begin
               xstart  = 1'b1;
               state_d = ST_COUNT;
            end
         end
         ST_WAIT_POWER_UP_DELAY_TIMER: begin
            if (power_up_delay_done) begin
               xstart  = 1'b1;
               state_d = ST_COUNT;
            end
         end
         ST_COUNT: begin
            if (xdone) begin
               state_d = ST_DONE;
            end
         end
         ST_DONE: begin
            if (sleep_wake && xtal_mode) begin
               xstart  = 1'b1;
               state_d = ST_COUNT;
            end
         end
      endcase
      if (xstart) begin
         first_d = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
         first_q <= 1'b0;
      end else begin
         state_q <= state_d;
         first_q <= first_d;
      end
   end

   xtal_startup_counter #(
      .COUNT (XTAL_COUNT)
   ) u_xtal (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .start   (xstart),
      .osc_in  (primary_osc_input_pin),
      .done    (xdone)
   );

   // Internal block is the clock when the default source is internal
   // and select is 00, or whenever select is 1x.
   assign intsel = sel_q[1] ||
                   ((sel_q == clk_src_pkg::SEL_DEFAULT) &&
                    (osc_mode_cfg == clk_src_pkg::DEFAULT_SRC_INTERNAL));
   // Monitor or dual speed keeps the internal block up during the count.
   assign intrun = intsel || (xtal_mode && (state_q != ST_DONE) &&
                   (clock_failure_monitor_en || dual_speed_en));
   assign hf_en = intrun && clk_src_pkg::is_hf_sel(fsel_q);
   assign mf_en = intrun && clk_src_pkg::is_mf_sel(fsel_q);
   assign lf_en = intrun && (fsel_q == clk_src_pkg::FREQ_SEL_LF);
   assign shift = clk_src_pkg::post_shift(fsel_q);

   // The HF source is the MF reference multiplied; modelled as a faster
   // tick that runs whenever hf_en is set, with no dependence on the MF model.
   int_osc_model #(
      .SRC_DIV  (8),
      .LOCK_CYC (clk_src_pkg::HF_LOCK_CYC),
      .STAB_CYC (clk_src_pkg::HF_STABLE_CYC)
   ) u_hf (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .enable  (hf_en),
      .shift   (shift),
      .ready   (hf_rdy),
      .locked  (hf_lck),
      .stable  (hf_stb),
      .tick    (hf_tick)
   );

   int_osc_model #(
      .SRC_DIV  (250),
      .LOCK_CYC (clk_src_pkg::MF_READY_CYC),
      .STAB_CYC (clk_src_pkg::MF_READY_CYC)
   ) u_mf (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .enable  (mf_en),
      .shift   (shift),
      .ready   (mf_rdy),
      .locked  (),
      .stable  (),
      .tick    (mf_tick)
   );

   int_osc_model #(
      .SRC_DIV  (4032),
      .LOCK_CYC (1),
      .STAB_CYC (1)
   ) u_lf (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .enable  (lf_en),
      .shift   (4'h0),
      .ready   (),
      .locked  (),
      .stable  (),
      .tick    (lf_tick)
   );

   // Fast start model times the HF power-up window; HF ticks reach the system tick only once it locks when the internal block is selected.
   int_osc_model #(
      .SRC_DIV  (1),
      .LOCK_CYC (clk_src_pkg::FAST_START_CYC),
      .STAB_CYC (clk_src_pkg::FAST_START_CYC)
   ) u_fast (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .enable  (hf_en),
      .shift   (4'h0),
      .ready   (),
      .locked  (fast_rdy),
      .stable  (),
      .tick    ()
   );

   // System tick mux; the crystal path is only released after the count.
   always_comb begin
      sys_tick = 1'b0;
      if (sel_q == clk_src_pkg::SEL_SECONDARY) begin
         sys_tick = secondary_osc_tick;
      end else if (intsel) begin
         sys_tick = (hf_tick && fast_rdy) || mf_tick || lf_tick;
      end else if (state_q == ST_DONE) begin
         sys_tick = primary_osc_input_pin;
      end else if (clock_failure_monitor_en || dual_speed_en) begin
         sys_tick = hf_tick || mf_tick || lf_tick;
      end
   end

   logic hold_d;
   logic mult_d;
   assign hold_d = xtal_mode && !intsel &&
                   (sel_q == clk_src_pkg::SEL_DEFAULT) &&
                   (state_q != ST_DONE) &&
                   !(clock_failure_monitor_en || dual_speed_en);
   assign mult_d = nv_multiplier_enable || sw_multiplier_enable;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         clk_select            <= clk_src_pkg::SEL_RESET;
         internal_freq_select  <= clk_src_pkg::FREQ_SEL_RESET;
         frequency_trim        <= clk_src_pkg::TRIM_RESET;
         multiplier_on         <= 1'b0;
         hf_ready_flag         <= 1'b0;
         hf_locked_flag        <= 1'b0;
         hf_stable_flag        <= 1'b0;
         mf_ready_flag         <= 1'b0;
         hf_enable             <= 1'b0;
         mf_enable             <= 1'b0;
         lf_enable             <= 1'b0;
         xtal_startup_done     <= 1'b0;
         cpu_hold              <= 1'b0;
         sys_clk_tick          <= 1'b0;
         osc_out_pin_is_clkout <= 1'b0;
         osc_in_pin_is_gpio    <= 1'b0;
      end else begin
         clk_select            <= sel_q;
         internal_freq_select  <= fsel_q;
         frequency_trim        <= trim_q;
         multiplier_on         <= mult_d;
         hf_ready_flag         <= hf_rdy;
         hf_locked_flag        <= hf_lck;
         hf_stable_flag        <= hf_stb;
         mf_ready_flag         <= mf_rdy;
         hf_enable             <= hf_en;
         mf_enable             <= mf_en;
         lf_enable             <= lf_en;
         xtal_startup_done     <= (state_q == ST_DONE) && !first_q;
         cpu_hold              <= hold_d;
         sys_clk_tick          <= sys_tick;
         osc_out_pin_is_clkout <= clock_output_pin_config &&
            ((osc_mode_cfg == clk_src_pkg::MODE_EXTERNAL_RC_MODE) ||
             (osc_mode_cfg == clk_src_pkg::MODE_INTERNAL_OSCILLATOR_BLOCK) ||
             ext_mode);
         osc_in_pin_is_gpio    <=
            (osc_mode_cfg == clk_src_pkg::MODE_INTERNAL_OSCILLATOR_BLOCK);
      end
   end
endmodule

// ### design/clk_src_pkg.sv
// Purpose: Shared constants and types for the clock-source control block.
// Assumes: One 125 MHz reference clock; oscillators are modelled digitally.
// Notes:   Reset values and start-up and settling counts live here; oscillator divide counts are set in the top module.
package clk_src_pkg;

   localparam int unsigned REF_CLK_MHZ = 125;

   // Oscillator-mode configuration codes.
   typedef enum logic [2:0] {
      MODE_ECL     = 3'h0,
      MODE_ECM     = 3'h1,
      MODE_ECH     = 3'h2,
      MODE_LP      = 3'h3,
      MODE_INTERNAL_OSCILLATOR_BLOCK  = 3'h4,
      MODE_XT      = 3'h5,
      MODE_HS      = 3'h6,
      MODE_EXTERNAL_RC_MODE   = 3'h7
   } osc_mode_t;

   // Default-source code that means the internal oscillator block.
   localparam logic [2:0] DEFAULT_SRC_INTERNAL = 3'h4;

   // Crystal start-up count in primary oscillator cycles.
   localparam int unsigned XTAL_STARTUP_CYCLES = 1024;

   // System-clock-select encodings.
   localparam logic [1:0] SEL_DEFAULT   = 2'h0;
   localparam logic [1:0] SEL_SECONDARY = 2'h1;
   localparam logic [1:0] SEL_RESET     = 2'h0;

   // Frequency-select field.
   localparam logic [3:0] FREQ_SEL_RESET = 4'h7;
   localparam logic [3:0] FREQ_SEL_PLL8M = 4'hE;
   localparam logic [3:0] FREQ_SEL_LF    = 4'h0;

   // Tuning reset value.
   localparam logic [5:0] TRIM_RESET = 6'h00;

   // Settling times of the modelled internal oscillators, in ns.
   localparam int unsigned FAST_START_NS = 200;
   localparam int unsigned HF_LOCK_NS    = 2000;
   localparam int unsigned HF_STABLE_NS  = 4000;
   localparam int unsigned MF_READY_NS   = 400;

   function automatic int unsigned ns_to_cycles(input int unsigned ns);
      int unsigned c;
      c = (ns * REF_CLK_MHZ + 999) / 1000;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int unsigned FAST_START_CYC = ns_to_cycles(FAST_START_NS);
   localparam int unsigned HF_LOCK_CYC    = ns_to_cycles(HF_LOCK_NS);
   localparam int unsigned HF_STABLE_CYC  = ns_to_cycles(HF_STABLE_NS);
   localparam int unsigned MF_READY_CYC   = ns_to_cycles(MF_READY_NS);

   // Postscaler divide per frequency-select code, as a power of two.
   // HF settings 0xF..0xA divide the 16 MHz source; MF 0x9..0x1 the 500 kHz.
   function automatic logic [3:0] post_shift(input logic [3:0] sel);
      logic [3:0] s;
      s = 4'h0;
      unique case (sel)
         4'hF:    s = 4'h0;
         4'hE:    s = 4'h1;
         4'hD:    s = 4'h2;
         4'hC:    s = 4'h3;
         4'hB:    s = 4'h4;
         4'hA:    s = 4'h5;
         4'h9:    s = 4'h6;
         4'h8:    s = 4'h7;
         4'h7:    s = 4'h0;
         4'h6:    s = 4'h1;
         4'h5:    s = 4'h2;
         4'h4:    s = 4'h3;
         4'h3:    s = 4'h4;
         4'h2:    s = 4'h5;
         4'h1:    s = 4'h6;
         default: s = 4'h0;
      endcase
      return s;
   endfunction

   function automatic logic is_hf_sel(input logic [3:0] sel);
      return sel >= 4'hA;
   endfunction

   function automatic logic is_mf_sel(input logic [3:0] sel);
      return (sel != FREQ_SEL_LF) && (sel < 4'hA);
   endfunction

endpackage

// ### design/xtal_startup_counter.sv
// Purpose: Counts primary oscillator cycles after a start event.
// Assumes: The oscillator input is already synchronous to ref_clk.
// Notes:   done stays high until the next start request.
`timescale 1ns/1ps
module xtal_startup_counter #(
   parameter int unsigned COUNT = clk_src_pkg::XTAL_STARTUP_CYCLES
) (
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic start,
   input  wire logic osc_in,
   output logic      done
);
   localparam int unsigned W = $clog2(COUNT + 1);

   initial begin
      if (COUNT < 2) begin
         $error("COUNT must be at least 2");
      end
   end

   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   logic         run_q;
   logic         run_d;
   logic         prev_q;
   logic         prev_d;
   logic         done_q;
   logic         done_d;

   always_comb begin
      cnt_d  = cnt_q;
      run_d  = run_q;
      done_d = done_q;
      prev_d = osc_in;
      if (start) begin
         cnt_d  = '0;
         run_d  = 1'b1;
         done_d = 1'b0;
      end else if (run_q && osc_in && !prev_q) begin
         if (cnt_q == W'(COUNT - 1)) begin
            run_d  = 1'b0;
            done_d = 1'b1;
         end
         cnt_d = cnt_q + 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q  <= '0;
         run_q  <= 1'b0;
         done_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         run_q  <= run_d;
         done_q <= done_d;
         prev_q <= prev_d;
      end
   end

   assign done = done_q;
endmodule

// ### design/int_osc_model.sv
// Purpose: Digital model of one internal oscillator with postscaler.
// Assumes: Source rate is one enable pulse every SRC_DIV ref_clk cycles.
// Notes:   Ready follows enable after a start time; flags drop on disable.
`timescale 1ns/1ps
module int_osc_model #(
   parameter int unsigned SRC_DIV  = 8,
   parameter int unsigned LOCK_CYC = 1,
   parameter int unsigned STAB_CYC = 1
) (
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   input  wire logic       enable,
   input  wire logic [3:0] shift,
   output logic            ready,
   output logic            locked,
   output logic            stable,
   output logic            tick
);
   localparam int unsigned TW = $clog2(STAB_CYC + 2);
   localparam int unsigned DW = $clog2(SRC_DIV + 1);

   initial begin
      if (SRC_DIV < 1 || LOCK_CYC > STAB_CYC) begin
         $error("Bad oscillator model parameters");
      end
   end

   logic [TW-1:0] age_q, age_d;
   logic [DW-1:0] div_q, div_d;
   logic [7:0]    post_q, post_d;
   logic          tick_q, tick_d;
   logic          src;

   always_comb begin
      age_d  = age_q;
      div_d  = div_q;
      post_d = post_q;
      tick_d = 1'b0;
      src    = 1'b0;
      if (!enable) begin
         age_d  = '0;
         div_d  = '0;
         post_d = '0;
      end else begin
         if (age_q != TW'(STAB_CYC)) begin
            age_d = age_q + 1'b1;
         end
         if (div_q == DW'(SRC_DIV - 1)) begin
            div_d = '0;
            src   = 1'b1;
         end else begin
            div_d = div_q + 1'b1;
         end
         if (src) begin
            post_d = post_q + 1'b1;
            tick_d = ((post_q + 8'h01) & ((8'h01 << shift) - 8'h01)) == 8'h00;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         age_q  <= '0;
         div_q  <= '0;
         post_q <= '0;
         tick_q <= 1'b0;
      end else begin
         age_q  <= age_d;
         div_q  <= div_d;
         post_q <= post_d;
         tick_q <= tick_d;
      end
   end

   assign ready  = enable && (age_q != '0);
   assign locked = enable && (age_q >= TW'(LOCK_CYC));
   assign stable = enable && (age_q == TW'(STAB_CYC));
   assign tick   = tick_q;
endmodule

// ### tb/system_clock_source_control_monitor.sv
// Purpose: Port-level assertions for the clock-source control block.
// Assumes: Single ref_clk domain, rst_n asynchronous active low.
// Notes:   Settling is judged by run-length counters, not fixed delays.
`timescale 1ns/1ps
module system_clock_source_control_monitor (
   input wire logic       ref_clk,
   input wire logic       rst_n,
   input wire logic [2:0] osc_mode_cfg,
   input wire logic       nv_multiplier_enable,
   input wire logic       sw_multiplier_enable,
   input wire logic       clock_output_pin_config,
   input wire logic       clock_failure_monitor_en,
   input wire logic       dual_speed_en,
   input wire logic [1:0] clk_select_wr_data,
   input wire logic       clk_select_wr,
   input wire logic [1:0] clk_select,
   input wire logic [3:0] internal_freq_select,
   input wire logic       multiplier_on,
   input wire logic       hf_ready_flag,
   input wire logic       hf_locked_flag,
   input wire logic       hf_stable_flag,
   input wire logic       mf_ready_flag,
   input wire logic       hf_enable,
   input wire logic       mf_enable,
   input wire logic       xtal_startup_done,
   input wire logic       cpu_hold,
   input wire logic       osc_out_pin_is_clkout,
   input wire logic       osc_in_pin_is_gpio
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   logic [9:0] hf_run_q;
   logic [9:0] hf_run_d;
   logic [9:0] mf_run_q;
   logic [9:0] mf_run_d;
   // Saturating run lengths let settling bounds exceed repetition limits.
   always_comb begin
      hf_run_d = hf_enable ? hf_run_q + 10'(hf_run_q != 10'h3FF) : 10'h0;
      mf_run_d = mf_enable ? mf_run_q + 10'(mf_run_q != 10'h3FF) : 10'h0;
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         hf_run_q <= 10'h000;
         mf_run_q <= 10'h000;
      end else begin
         hf_run_q <= hf_run_d;
         mf_run_q <= mf_run_d;
      end
   end
   AST_MULT: assert property (
      (nv_multiplier_enable || sw_multiplier_enable)[*3] |-> multiplier_on)
      else $error("multiplier off although an enable is set");
   AST_SEL: assert property (
      clk_select_wr ##1 !clk_select_wr |->
      ##1 clk_select == $past(clk_select_wr_data, 2))
      else $error("clock select does not mirror the write");
   AST_HOLD_OFF: assert property (
      (clock_failure_monitor_en || dual_speed_en)[*3] |-> !cpu_hold)
      else $error("cpu held while monitor or dual speed enabled");
   AST_HOLD_DONE: assert property (cpu_hold |-> !xtal_startup_done)
      else $error("cpu held after start-up count done");
   AST_EC: assert property (
      (osc_mode_cfg <= 3'h2)[*6] |-> xtal_startup_done && !cpu_hold)
      else $error("external clock mode waits for start-up count");
   AST_PIN: assert property (
      (osc_mode_cfg == clk_src_pkg::MODE_INTERNAL_OSCILLATOR_BLOCK)[*3] |-> osc_in_pin_is_gpio)
      else $error("primary input pin not freed in internal mode");
   AST_CLKOUT: assert property (
      (osc_mode_cfg == clk_src_pkg::MODE_EXTERNAL_RC_MODE &&
       clock_output_pin_config)[*3] |-> osc_out_pin_is_clkout)
      else $error("clock output not routed in RC mode");
   AST_HF_EN: assert property (
      (internal_freq_select >= 4'hA && clk_select[1])[*3] |->
      hf_enable && !mf_enable)
      else $error("high-frequency enable wrong for HF setting");
   AST_MF_EN: assert property (
      (internal_freq_select inside {[4'h1:4'h9]} && clk_select[1])[*3] |->
      mf_enable && !hf_enable)
      else $error("mid-frequency enable wrong for MF setting");
   AST_HF_SEQ: assert property (
      hf_run_q == 10'd500 |->
      hf_ready_flag && hf_locked_flag && hf_stable_flag)
      else $error("high-frequency flags not set after settling");
   AST_MF_RDY: assert property (mf_run_q == 10'd4 |-> mf_ready_flag)
      else $error("mid-frequency ready flag not set");
   AST_CLR: assert property (
      (!hf_enable && !mf_enable)[*2] |->
      !(hf_ready_flag || hf_locked_flag || hf_stable_flag || mf_ready_flag))
      else $error("oscillator flag left set while disabled");
   cover property ($rose(xtal_startup_done));
   cover property ($rose(hf_stable_flag));
   cover property ($rose(mf_ready_flag));
endmodule
bind system_clock_source_control system_clock_source_control_monitor mon_inst (
   .ref_clk(ref_clk), .rst_n(rst_n), .osc_mode_cfg(osc_mode_cfg),
   .nv_multiplier_enable(nv_multiplier_enable),
   .sw_multiplier_enable(sw_multiplier_enable),
   .clock_output_pin_config(clock_output_pin_config),
   .clock_failure_monitor_en(clock_failure_monitor_en),
   .dual_speed_en(dual_speed_en), .clk_select_wr_data(clk_select_wr_data),
   .clk_select_wr(clk_select_wr), .clk_select(clk_select),
   .internal_freq_select(internal_freq_select),
   .multiplier_on(multiplier_on), .hf_ready_flag(hf_ready_flag),
   .hf_locked_flag(hf_locked_flag), .hf_stable_flag(hf_stable_flag),
   .mf_ready_flag(mf_ready_flag), .hf_enable(hf_enable),
   .mf_enable(mf_enable), .xtal_startup_done(xtal_startup_done),
   .cpu_hold(cpu_hold), .osc_out_pin_is_clkout(osc_out_pin_is_clkout),
   .osc_in_pin_is_gpio(osc_in_pin_is_gpio)
);

// ### tb/xtal_partner.sv
// Purpose: Behavioural crystal on the primary pin and timekeeping crystal.
// Assumes: Waveform is already synchronous to ref_clk.
// Notes:   A stopped crystal rests low; the secondary one runs freely.
`timescale 1ns/1ps
module xtal_partner (
   input  wire logic ref_clk,
   input  wire logic run,
   output logic      osc,
   output logic      sec_tick
);
   logic [1:0] div_q = 2'h0;
   logic [2:0] sec_q = 3'h0;
   // Two low and two high samples per cycle, so every edge is seen.
   always @(posedge ref_clk) begin
      if (run) div_q <= div_q + 2'h1;
      sec_q <= sec_q + 3'h1;
   end
   assign osc = run && div_q[1];
   assign sec_tick = (sec_q == 3'h7);
endmodule

// ### tb/system_clock_source_control_test.sv
// Purpose: Directed test of start-up, selection and oscillator enables.
// Assumes: Start-up count shortened to XC cycles.
// Notes:   Inputs change by non-blocking assignment at rising edges.
`timescale 1ns/1ps
module system_clock_source_control_test;
   localparam int unsigned XC = 8;
   logic ref_clk = 1'b0, rst_n = 1'b0, xrun = 1'b0, osc, sec, osc_d = 1'b0;
   logic [2:0] mode = 3'h0;
   logic nv = 1'b0, sw = 1'b0, ck_cfg = 1'b0, clock_failure_monitor = 1'b0, dual = 1'b0;
   logic pw_en = 1'b1, pw_done = 1'b0, wake = 1'b0;
   logic sel_wr = 1'b0, fs_wr = 1'b0, tr_wr = 1'b0;
   logic [1:0] sel_dat = 2'h0;
   logic [3:0] fs_dat = 4'h0;
   logic [5:0] tr_dat = 6'h00;
   logic [1:0] clk_select;
   logic [3:0] ifs;
   logic [5:0] trim;
   logic mult, hf_r, hf_l, hf_s, mf_r, hf_en, mf_en, lf_en, done, hold, tick;
   logic clkout, gpio;
   int n_mismatch = 0, n_compared = 0, n_edge = 0, e0, i;
   always #4 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      osc_d <= osc;
      if (osc && !osc_d) n_edge <= n_edge + 1;
   end
   xtal_partner xtal_partner_inst (.ref_clk(ref_clk), .run(xrun), .osc(osc),
      .sec_tick(sec));
   system_clock_source_control #(.XTAL_COUNT(XC))
      system_clock_source_control_inst (
      .ref_clk(ref_clk), .rst_n(rst_n), .osc_mode_cfg(mode),
      .nv_multiplier_enable(nv), .clock_output_pin_config(ck_cfg),
      .clock_failure_monitor_en(clock_failure_monitor), .dual_speed_en(dual),
      .power_up_delay_en(pw_en), .power_up_delay_done(pw_done),
      .sleep_wake(wake), .primary_osc_input_pin(osc), .secondary_osc_tick(sec),
      .sw_multiplier_enable(sw), .clk_select_wr_data(sel_dat),
      .clk_select_wr(sel_wr), .freq_select_wr_data(fs_dat),
      .freq_select_wr(fs_wr), .trim_wr_data(tr_dat), .trim_wr(tr_wr),
      .clk_select(clk_select), .internal_freq_select(ifs),
      .frequency_trim(trim), .multiplier_on(mult), .hf_ready_flag(hf_r),
      .hf_locked_flag(hf_l), .hf_stable_flag(hf_s), .mf_ready_flag(mf_r),
      .hf_enable(hf_en), .mf_enable(mf_en), .lf_enable(lf_en),
      .xtal_startup_done(done), .cpu_hold(hold), .sys_clk_tick(tick),
      .osc_out_pin_is_clkout(clkout), .osc_in_pin_is_gpio(gpio));
   task automatic test_done();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic do_reset(input logic [2:0] m);
      rst_n <= 1'b0;
      mode <= m;
      xrun <= 1'b0;
      cyc(16);
      rst_n <= 1'b1;
      cyc(2);
   endtask
   // Kind 0 selects the source, 1 the frequency, 2 the trim.
   task automatic wr(input int k, input logic [5:0] d);
      sel_wr <= (k == 0);
      fs_wr <= (k == 1);
      tr_wr <= (k == 2);
      sel_dat <= d[1:0];
      fs_dat <= d[3:0];
      tr_dat <= d;
      cyc(1);
      sel_wr <= 1'b0;
      fs_wr <= 1'b0;
      tr_wr <= 1'b0;
      cyc(3);
   endtask
   task automatic wait_for(input int w, input int lim);
      int k;
      logic [3:0] ev;
      for (k = 0; k < lim; k++) begin
         cyc(1);
         ev = {tick, mf_r, hf_s, done};
         if (ev[w] === 1'b1) break;
      end
      if (k == lim) begin
         n_mismatch++;
         $display("timeout waiting for event %0d", w);
         test_done();
      end
   endtask
   initial begin
      do_reset(clk_src_pkg::MODE_HS);
      chk(clk_select, 2'h0);
      chk(ifs, 4'h7);
      chk(trim, 6'h00);
      chk(gpio, 1'b0);
      xrun <= 1'b1;
      cyc(40);
      chk(done, 1'b0);
      pw_done <= 1'b1;
      e0 = n_edge;
      cyc(8);
      chk(hold, 1'b1);
      wait_for(0, 400);
      chk(n_edge - e0 >= XC, 1'b1);
      cyc(2);
      chk(hold, 1'b0);
      wake <= 1'b1;
      cyc(1);
      wake <= 1'b0;
      e0 = n_edge;
      cyc(4);
      chk(done, 1'b0);
      wait_for(0, 400);
      chk(n_edge - e0 >= XC, 1'b1);
      for (i = 0; i < 4; i++) begin
         nv <= i[1];
         sw <= i[0];
         cyc(4);
         chk(mult, i[1] | i[0]);
      end
      xrun <= 1'b0;
      for (i = 1; i < 5; i++) begin
         wr(0, 6'(i % 4));
         chk(clk_select, 16'(i % 4));
         if (i == 1) wait_for(3, 40);
      end
      $display("test crystal and select finished");
      clock_failure_monitor <= 1'b1;
      do_reset(clk_src_pkg::MODE_LP);
      xrun <= 1'b1;
      cyc(10);
      chk(hold, 1'b0);
      wait_for(0, 400);
      clock_failure_monitor <= 1'b0;
      do_reset(clk_src_pkg::MODE_ECH);
      cyc(4);
      chk(done, 1'b1);
      chk(hold, 1'b0);
      $display("test start-up modes finished");
      do_reset(clk_src_pkg::MODE_INTERNAL_OSCILLATOR_BLOCK);
      chk(gpio, 1'b1);
      for (i = 0; i < 2; i++) begin
         ck_cfg <= i[0];
         cyc(4);
         chk(clkout, i[0]);
      end
      wr(0, 6'h02);
      for (i = 0; i < 16; i++) begin
         wr(1, 6'(i));
         chk(hf_en, i >= 10);
         chk(mf_en, i >= 1 && i <= 9);
         if (i == 0) chk(lf_en, 1'b1);
      end
      wr(1, 6'h0F);
      wait_for(1, 1000);
      chk({hf_r, hf_l, hf_s}, 3'h7);
      wr(1, 6'h07);
      chk({hf_r, hf_l, hf_s}, 3'h0);
      wait_for(2, 200);
      chk(mf_r, 1'b1);
      wr(0, 6'h00);
      chk(mf_en, 1'b1);
      wr(0, 6'h01);
      chk(mf_en, 1'b0);
      wr(2, 6'h20);
      chk(trim, 6'h20);
      $display("test internal oscillators finished");
      test_done();
   end
endmodule
